// ===== src/fsc_pkg.sv
// Purpose: shared constants and types of the frequency entry and sweep control
// Assumes: 32-bit frequency words in hertz
// Notes: register offsets are byte addresses on the AXI4-Lite slave
package fsc_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS_DFLT = CLK_HZ / MS_PER_S;
  localparam logic [5:0] FAST_STEP_MS = 6'h01;
  localparam logic [5:0] MED_STEP_MS = 6'h01;
  localparam logic [5:0] SLOW_STEP_MS = 6'h32;
  localparam logic [9:0] FAST_STEPS = 10'h064;
  localparam logic [9:0] MED_STEPS = 10'h3E8;
  localparam logic [9:0] SLOW_STEPS = 10'h3E8;
  localparam logic [9:0] MAN_STEPS = 10'h3E8;
  localparam logic [9:0] MAN_MID = 10'h1F4;

  // ----------------------------------------
  // frequencies in hertz
  // ----------------------------------------
  localparam logic [31:0] TUNE_FINE_HZ = 32'h00000001;
  localparam logic [31:0] TUNE_MED_HZ = 32'h000003E8;
  localparam logic [31:0] TUNE_COARSE_HZ = 32'h000F4240;
  localparam logic [31:0] HIGH_BAND_HZ = 32'h4D7C6D00;
  localparam logic [31:0] OPT_RES_HZ = 32'h00000064;
  localparam logic [31:0] OPT_RES_HI_HZ = 32'h000000C8;
  localparam logic [31:0] DECADE = 32'h0000000A;
  localparam logic [31:0] RST_CF_HZ = 32'h000F4240;
  localparam logic [31:0] RST_UPPER_HZ = 32'h4D7C6D00;
  localparam logic [31:0] RST_LOWER_HZ = 32'h00002710;
  localparam logic [3:0] UEXP_HZ = 4'h0;
  localparam logic [3:0] UEXP_KHZ = 4'h3;
  localparam logic [3:0] UEXP_MHZ = 4'h6;
  localparam logic [3:0] UEXP_GHZ = 4'h9;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RCTRL = 8'h04;
  localparam logic [7:0] OFS_KEY = 8'h08;
  localparam logic [7:0] OFS_RKEY = 8'h0C;
  localparam logic [7:0] OFS_UPPER = 8'h10;
  localparam logic [7:0] OFS_LOWER = 8'h14;
  localparam logic [7:0] OFS_OPTION = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_READOUT = 8'h24;
  localparam logic [7:0] OFS_KEYBOARD = 8'h28;
  localparam logic [7:0] OFS_CENTER = 8'h2C;
  localparam logic [7:0] OFS_STEP = 8'h30;
  localparam logic [7:0] OFS_WIDTH = 8'h34;
  localparam logic [7:0] OFS_OUTPUT = 8'h38;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // key codes, modes, rates, resolutions
  // ----------------------------------------
  localparam logic [4:0] KEY_POINT = 5'h0A;
  localparam logic [4:0] KEY_CLEAR = 5'h0B;
  localparam logic [4:0] KEY_HZ = 5'h0C;
  localparam logic [4:0] KEY_KHZ = 5'h0D;
  localparam logic [4:0] KEY_MHZ = 5'h0E;
  localparam logic [4:0] KEY_GHZ = 5'h0F;
  localparam logic [4:0] KEY_CF = 5'h10;
  localparam logic [4:0] KEY_UP = 5'h11;
  localparam logic [4:0] KEY_DOWN = 5'h12;
  localparam logic [4:0] KEY_WIDTH = 5'h13;
  localparam logic [4:0] KEY_SINGLE = 5'h14;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_SINGLE = 2'h2;
  localparam logic [1:0] MODE_MAN = 2'h3;
  localparam logic [1:0] RATE_FAST = 2'h0;
  localparam logic [1:0] RATE_MED = 2'h1;
  localparam logic [1:0] RATE_SLOW = 2'h2;
  localparam logic [1:0] RES_FINE = 2'h0;
  localparam logic [1:0] RES_MED = 2'h1;
  localparam logic [1:0] RES_COARSE = 2'h2;
  localparam logic [1:0] RES_STEP = 2'h3;

  // view bit 0 keyboard, bit 1 step, bit 2 sweep width
  typedef struct packed {
    logic [2:0] view;
    logic [1:0] res;
    logic [1:0] rate;
    logic [1:0] mode;
  } fsc_ctrl_s;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_RUN = 3'b010,
    SW_MAN = 3'b100
  } fsc_sweep_e;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } fsc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fsc_axi_rsp_s;

  typedef struct packed {
    fsc_ctrl_s ctrl_p;
    fsc_ctrl_s ctrl_r;
    logic [31:0] upper;
    logic [31:0] lower;
    logic coarse_opt;
    logic [31:0] mant;
    logic [3:0] frac;
    logic point;
    logic scaled;
    logic kb_new;
    logic [31:0] kb;
    logic [31:0] cf;
    logic [31:0] step;
    logic [31:0] width;
    logic [31:0] outf;
    logic [31:0] readout;
    logic [31:0] sw_off;
    logic [9:0] sw_idx;
    fsc_sweep_e sw_st;
    logic lamp;
    logic sweep_lamp;
    logic rejected;
    logic enc_prev;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } fsc_state_s;

endpackage : fsc_pkg

// ===== src/fsc_sync.sv
// Purpose: two-flop synchroniser for panel and remote pins
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module fsc_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
  } fsc_sync_s;

  fsc_sync_s s;
  fsc_sync_s next_s;

  always_comb
  begin
    next_s.ff1 = din;
    next_s.ff2 = s.ff1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= {RST_VAL, RST_VAL};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign dout = s.ff2;

endmodule : fsc_sync
`default_nettype wire

// ===== src/fsc_step_timer.sv
// Purpose: sweep step period timer in whole milliseconds
// Assumes: run falls only when sweeping stops
// Notes: tick is a one-cycle registered pulse
`timescale 1ns/1ps
`default_nettype none
module fsc_step_timer #(
  parameter int unsigned CYC_PER_MS = fsc_pkg::CYC_PER_MS_DFLT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [5:0] ms_per_step,
  output logic tick
);

  localparam int unsigned CW = $clog2(CYC_PER_MS + 1);

  typedef struct packed {
    logic [CW-1:0] cyc;
    logic [5:0] ms;
    logic tick;
  } fsc_tmr_s;

  fsc_tmr_s s;
  fsc_tmr_s next_s;

  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run)
    begin
      next_s.cyc = '0;
      next_s.ms = '0;
    end
    else if (s.cyc == CW'(CYC_PER_MS - 1))
    begin
      next_s.cyc = '0;
      if (s.ms == 6'(ms_per_step - 6'h01))
      begin
        next_s.ms = '0;
        next_s.tick = 1'b1;
      end
      else
      begin
        next_s.ms = 6'(s.ms + 6'h01);
      end
    end
    else
    begin
      next_s.cyc = CW'(s.cyc + 1'b1);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule : fsc_step_timer
`default_nettype wire

// ===== src/fsc_freq_ctrl.sv
// Purpose: keyboard entry, center/step/width registers, sweep and tuning
// Assumes: panel keys arrive as writes to the key register, remote ones to
//   the remote key register; encoder and mode pins are asynchronous
// Notes: output word is the instantaneous frequency for the output section
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - entries resolve 1 Hz, 2 Hz high band
// - over-limit entry stays in keyboard only
// - under-limit entry loads, lamp stays lit
// - view buttons show keyboard, step, width
// - clear key empties keyboard register only
// - center key loads keyboard into center
// - step up loads new step, raises center
// - step down likewise, lowers center
// - width key loads keyboard into width
// - rate picks step count and period
// - auto sweep spans width around center
// - single press runs one sweep, returns
// - manual sweep steps width/1000 per increment
// - readout shows center, or output in manual
// - step held until overwritten or standby
// - step resolution tunes by step register
// - tuning steps 1 Hz, 1 kHz, 1 MHz
// - modes combine; manual sweep blocks tuning
// - remote select locks out panel controls
// - digits shift in; unit key scales
module fsc_freq_ctrl #(
  parameter int unsigned CYC_PER_MS = fsc_pkg::CYC_PER_MS_DFLT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire fsc_pkg::fsc_axi_req_s axi_req,
  output var fsc_pkg::fsc_axi_rsp_s axi_rsp,
  input wire logic remote_sel_n,
  input wire logic standby,
  input wire logic enc_pulse,
  input wire logic enc_up,
  output logic [31:0] freq_word,
  output logic [31:0] readout,
  output logic out_of_range_lamp,
  output logic sweep_lamp
);
  import fsc_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] scale_entry(input logic [31:0] mant,
                                              input logic [3:0] frac,
                                              input logic [3:0] uexp);
    logic [31:0] v;
    int e;
    v = mant;
    e = int'(uexp) - int'(frac);
    for (int i = 0; i < 10; i++)
    begin
      if (i < e)
        v = 32'(v * DECADE);
      if (i < -e)
        v = v / DECADE;
    end
    return v;
  endfunction : scale_entry

  function automatic logic [31:0] quantize(input logic [31:0] v, input logic opt);
    logic hi;
    hi = v > HIGH_BAND_HZ;
    if (!opt)
      return hi ? {v[31:1], 1'b0} : v;
    else
      return hi ? v - (v % OPT_RES_HI_HZ) : v - (v % OPT_RES_HZ);
  endfunction : quantize

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r;
  endfunction : wmerge

  // ----------------------------------------
  // pins and timer
  // ----------------------------------------
  fsc_state_s s;
  fsc_state_s next_s;
  logic [3:0] pins;
  logic tick;
  logic [5:0] step_ms;

  // remote select idles high, so it resets high to start local
  fsc_sync #(.W(4), .RST_VAL(4'h4)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({standby, remote_sel_n, enc_up, enc_pulse}),
    .dout(pins)
  );

  fsc_step_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(s.sw_st == SW_RUN),
    .ms_per_step(step_ms),
    .tick(tick)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic remote;
  logic stby;
  fsc_ctrl_s c;
  logic wr_go;
  logic rd_go;
  logic key_fire;
  logic [4:0] key;
  logic enc_ev;
  logic [31:0] cand;
  logic cand_en;
  logic [31:0] delta;
  logic [9:0] steps;
  logic [31:0] sw_inc;
  logic [31:0] man_inc;
  logic [31:0] half;
  logic [31:0] base;
  logic [31:0] kbv;

  always_comb
  begin
    next_s = s;
    remote = !pins[2];
    stby = pins[3];
    c = remote ? s.ctrl_r : s.ctrl_p;
    wr_go = axi_req.awvalid && axi_req.wvalid && !s.bvalid;
    rd_go = axi_req.arvalid && !s.rvalid;
    key_fire = 1'b0;
    key = axi_req.wdata[4:0];
    cand = s.cf;
    cand_en = 1'b0;
    kbv = s.scaled ? s.kb : s.mant;
    next_s.enc_prev = pins[0];
    // panel encoder has no effect under remote control
    enc_ev = pins[0] && !s.enc_prev && !remote;

    // bus writes
    if (s.bvalid && axi_req.bready)
      next_s.bvalid = 1'b0;
    if (wr_go)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case (axi_req.awaddr)
        OFS_CTRL: next_s.ctrl_p = fsc_ctrl_s'(9'(wmerge(32'(s.ctrl_p),
                    axi_req.wdata, axi_req.wstrb)));
        OFS_RCTRL: next_s.ctrl_r = fsc_ctrl_s'(9'(wmerge(32'(s.ctrl_r),
                     axi_req.wdata, axi_req.wstrb)));
        OFS_KEY: key_fire = axi_req.wstrb[0] && !remote;
        OFS_RKEY: key_fire = axi_req.wstrb[0] && remote;
        OFS_UPPER: next_s.upper = wmerge(s.upper, axi_req.wdata, axi_req.wstrb);
        OFS_LOWER: next_s.lower = wmerge(s.lower, axi_req.wdata, axi_req.wstrb);
        OFS_OPTION: next_s.coarse_opt = axi_req.wstrb[0] ? axi_req.wdata[0]
                                                           : s.coarse_opt;
        OFS_STATUS, OFS_READOUT, OFS_KEYBOARD, OFS_CENTER, OFS_STEP,
        OFS_WIDTH, OFS_OUTPUT: next_s.bresp = RESP_OKAY;
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end

    // keyboard
    if (key_fire)
    begin
      if (key < KEY_POINT)
      begin
        if (s.scaled)
        begin
          next_s.mant = 32'(key);
          next_s.frac = '0;
          next_s.point = 1'b0;
          next_s.scaled = 1'b0;
        end
        else
        begin
          next_s.mant = 32'(s.mant * DECADE + 32'(key));
          if (s.point)
            next_s.frac = 4'(s.frac + 4'h1);
        end
      end
      else
      begin
        case (key)
          KEY_POINT: next_s.point = 1'b1;
          KEY_CLEAR:
          begin
            next_s.mant = '0;
            next_s.frac = '0;
            next_s.point = 1'b0;
            next_s.scaled = 1'b0;
            next_s.kb_new = 1'b0;
            next_s.kb = '0;
          end
          KEY_HZ, KEY_KHZ, KEY_MHZ, KEY_GHZ:
          begin
            next_s.kb = quantize(scale_entry(s.mant, s.frac,
              key == KEY_HZ ? UEXP_HZ : key == KEY_KHZ ? UEXP_KHZ :
              key == KEY_MHZ ? UEXP_MHZ : UEXP_GHZ), s.coarse_opt);
            next_s.scaled = 1'b1;
            next_s.kb_new = 1'b1;
          end
          KEY_CF:
          begin
            cand = kbv;
            cand_en = 1'b1;
            next_s.kb_new = 1'b0;
          end
          KEY_UP, KEY_DOWN:
          begin
            delta = s.kb_new ? kbv : s.step;
            if (s.kb_new)
              next_s.step = kbv;
            next_s.kb_new = 1'b0;
            cand_en = 1'b1;
            if (key == KEY_UP)
              cand = ({1'b0, s.cf} + {1'b0, delta} > 33'(s.upper)) ? 32'hFFFFFFFF
                     : 32'(s.cf + delta);
            else
              cand_en = delta <= s.cf;
            if (key == KEY_DOWN)
              cand = 32'(s.cf - delta);
          end
          KEY_WIDTH:
          begin
            next_s.width = kbv;
            next_s.kb_new = 1'b0;
          end
          default: next_s.kb_new = s.kb_new;
        endcase
      end
    end

    // tuning encoder; manual sweep takes it over
    case (c.res)
      RES_FINE: delta = TUNE_FINE_HZ;
      RES_MED: delta = TUNE_MED_HZ;
      RES_COARSE: delta = TUNE_COARSE_HZ;
      default: delta = s.step;
    endcase
    if (enc_ev && !cand_en && c.mode != MODE_MAN)
    begin
      cand_en = pins[1] || delta <= s.cf;
      cand = pins[1] ? 32'(s.cf + delta) : 32'(s.cf - delta);
      if (pins[1] && {1'b0, s.cf} + {1'b0, delta} > 33'(s.upper))
        cand = 32'hFFFFFFFF;
    end

    // range check on every center load
    if (cand_en)
    begin
      if (cand > s.upper)
        next_s.rejected = 1'b1;
      else
      begin
        next_s.cf = cand;
        next_s.rejected = 1'b0;
      end
    end

    if (stby)
      next_s.step = '0;

    // sweep engine
    case (c.rate)
      RATE_FAST:
      begin
        steps = FAST_STEPS;
        step_ms = FAST_STEP_MS;
        sw_inc = s.width / 32'(FAST_STEPS);
      end
      RATE_SLOW:
      begin
        steps = SLOW_STEPS;
        step_ms = SLOW_STEP_MS;
        sw_inc = s.width / 32'(SLOW_STEPS);
      end
      default:
      begin
        steps = MED_STEPS;
        step_ms = MED_STEP_MS;
        sw_inc = s.width / 32'(MED_STEPS);
      end
    endcase
    man_inc = s.width / 32'(MAN_STEPS);
    half = {1'b0, s.width[31:1]};
    base = (s.cf >= half) ? s.cf - half : '0;

    case (s.sw_st)
      SW_IDLE:
      begin
        next_s.sw_idx = '0;
        next_s.sw_off = '0;
        if (!stby && c.mode == MODE_AUTO)
          next_s.sw_st = SW_RUN;
        else if (!stby && c.mode == MODE_SINGLE && key_fire && key == KEY_SINGLE)
          next_s.sw_st = SW_RUN;
        else if (!stby && c.mode == MODE_MAN)
        begin
          next_s.sw_st = SW_MAN;
          next_s.sw_idx = MAN_MID;
          next_s.sw_off = 32'(man_inc * 32'(MAN_MID));
        end
      end
      SW_RUN:
      begin
        if (stby || (c.mode != MODE_AUTO && c.mode != MODE_SINGLE))
          next_s.sw_st = SW_IDLE;
        else if (tick)
        begin
          if (s.sw_idx >= steps)
          begin
            next_s.sw_idx = '0;
            next_s.sw_off = '0;
            if (c.mode == MODE_SINGLE)
              next_s.sw_st = SW_IDLE;
          end
          else
          begin
            next_s.sw_idx = 10'(s.sw_idx + 10'h001);
            next_s.sw_off = 32'(s.sw_off + sw_inc);
          end
        end
      end
      SW_MAN:
      begin
        if (stby || c.mode != MODE_MAN)
          next_s.sw_st = SW_IDLE;
        else if (enc_ev && pins[1] && s.sw_idx < MAN_STEPS)
        begin
          next_s.sw_idx = 10'(s.sw_idx + 10'h001);
          next_s.sw_off = 32'(s.sw_off + man_inc);
        end
        else if (enc_ev && !pins[1] && s.sw_idx != '0)
        begin
          next_s.sw_idx = 10'(s.sw_idx - 10'h001);
          next_s.sw_off = 32'(s.sw_off - man_inc);
        end
      end
      default: next_s.sw_st = SW_IDLE;
    endcase

    // outputs, one cycle behind the state they show
    next_s.outf = (s.sw_st == SW_IDLE) ? s.cf : 32'(base + s.sw_off);
    next_s.lamp = s.outf < s.lower;
    next_s.sweep_lamp = s.sw_st != SW_IDLE;
    if (c.view[0])
      next_s.readout = kbv;
    else if (c.view[1])
      next_s.readout = s.step;
    else if (c.view[2])
      next_s.readout = s.width;
    else
      next_s.readout = (s.sw_st == SW_MAN) ? s.outf : s.cf;

    // bus reads
    if (s.rvalid && axi_req.rready)
      next_s.rvalid = 1'b0;
    if (rd_go)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      case (axi_req.araddr)
        OFS_CTRL: next_s.rdata = 32'(s.ctrl_p);
        OFS_RCTRL: next_s.rdata = 32'(s.ctrl_r);
        OFS_UPPER: next_s.rdata = s.upper;
        OFS_LOWER: next_s.rdata = s.lower;
        OFS_OPTION: next_s.rdata = 32'(s.coarse_opt);
        OFS_STATUS: next_s.rdata = {26'h0000000, s.scaled, s.kb_new,
                                     s.rejected, remote, s.sweep_lamp, s.lamp};
        OFS_READOUT: next_s.rdata = s.readout;
        OFS_KEYBOARD: next_s.rdata = kbv;
        OFS_CENTER: next_s.rdata = s.cf;
        OFS_STEP: next_s.rdata = s.step;
        OFS_WIDTH: next_s.rdata = s.width;
        OFS_OUTPUT: next_s.rdata = s.outf;
        OFS_KEY, OFS_RKEY: next_s.rdata = '0;
        default:
        begin
          next_s.rdata = '0;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.upper <= RST_UPPER_HZ;
      s.lower <= RST_LOWER_HZ;
      s.cf <= RST_CF_HZ;
      s.outf <= RST_CF_HZ;
      s.readout <= RST_CF_HZ;
      s.sw_st <= SW_IDLE;
      s.enc_prev <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  always_comb
  begin
    axi_rsp.awready = wr_go;
    axi_rsp.wready = wr_go;
    axi_rsp.bvalid = s.bvalid;
    axi_rsp.bresp = s.bresp;
    axi_rsp.arready = rd_go;
    axi_rsp.rvalid = s.rvalid;
    axi_rsp.rdata = s.rdata;
    axi_rsp.rresp = s.rresp;
  end

  assign freq_word = s.outf;
  assign readout = s.readout;
  assign out_of_range_lamp = s.lamp;
  assign sweep_lamp = s.sweep_lamp;

endmodule : fsc_freq_ctrl
`default_nettype wire

// ===== verif/fsc_freq_ctrl_assertions.sv
// Purpose: register port handshake checks
// Assumes: bound to fsc_freq_ctrl
// Notes: sees top ports only
`timescale 1ns/1ps
`default_nettype none
module fsc_freq_ctrl_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire fsc_pkg::fsc_axi_req_s axi_req,
  input wire fsc_pkg::fsc_axi_rsp_s axi_rsp
);
  import fsc_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_wr_taken: assert property (axi_req.awvalid && axi_req.wvalid && !axi_rsp.bvalid
    |-> axi_rsp.awready && axi_rsp.wready) else $error("write not taken");
  a_b_answer: assert property (axi_req.awvalid && axi_req.wvalid && !axi_rsp.bvalid
    |=> axi_rsp.bvalid) else $error("no write response");
  a_b_stands: assert property (axi_rsp.bvalid && !axi_req.bready
    |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write response lost");
  a_b_busy: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while busy");
  a_b_drops: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
    else $error("write response repeated");
  a_r_answer: assert property (axi_req.arvalid && !axi_rsp.rvalid |=> axi_rsp.rvalid)
    else $error("no read response");
  a_r_stands: assert property (axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data lost");
  a_r_busy: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while busy");
endmodule : fsc_freq_ctrl_chk
bind fsc_freq_ctrl fsc_freq_ctrl_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_rsp(axi_rsp));
`default_nettype wire

// ===== verif/fsc_panel_model.sv
// Purpose: tuning encoder of the front panel
// Assumes: one detent per turn call
// Notes: direction settles before the pulse rises
`timescale 1ns/1ps
`default_nettype none
module fsc_panel_model (
  input wire logic aclk,
  output logic enc_pulse,
  output logic enc_up
);
  initial
  begin
    enc_pulse = 1'b0;
    enc_up = 1'b0;
  end
  // slow pulse so the synchroniser never misses an edge
  task automatic turn(input logic up);
    begin
      @(posedge aclk);
      enc_up <= up;
      repeat (3) @(posedge aclk);
      enc_pulse <= 1'b1;
      repeat (6) @(posedge aclk);
      enc_pulse <= 1'b0;
      repeat (6) @(posedge aclk);
    end
  endtask : turn
endmodule : fsc_panel_model
`default_nettype wire

// ===== verif/frequency_entry_sweep_control_tb.sv
// Purpose: self-checking bench of the frequency control
// Assumes: short millisecond via CYC_PER_MS
// Notes: registers reached over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module frequency_entry_sweep_control_tb;
  import fsc_pkg::*;
  localparam int CPM = 10;
  localparam int LIM = 4000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic rsn = 1'b1;
  logic sb = 1'b0;
  fsc_axi_req_s rq = '0;
  fsc_axi_rsp_s rs;
  logic ep, eu, lamp, swl;
  logic [31:0] fw, ro, d, c, s, t, w;
  logic [1:0] rr;
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 21;
  int n;
  always #20 aclk = ~aclk;
  fsc_freq_ctrl #(.CYC_PER_MS(CPM)) dut (.aclk(aclk), .aresetn(aresetn), .axi_req(rq),
    .axi_rsp(rs), .remote_sel_n(rsn), .standby(sb), .enc_pulse(ep), .enc_up(eu),
    .freq_word(fw), .readout(ro), .out_of_range_lamp(lamp), .sweep_lamp(swl));
  fsc_panel_model panel (.aclk(aclk), .enc_pulse(ep), .enc_up(eu));
  task automatic finish_test;
    begin
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask : finish_test
  task automatic bnd(input int i);
    if (i >= LIM)
    begin
      miscompares++;
      finish_test();
    end
  endtask : bnd
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int i;
    begin
      rq.awvalid <= 1'b1;
      rq.wvalid <= 1'b1;
      rq.awaddr <= a;
      rq.wdata <= v;
      rq.wstrb <= 4'hF;
      i = 0;
      do
      begin
        @(posedge aclk);
        i++;
      end
      while (!(rs.awready && rs.wready) && i < LIM);
      rq.awvalid <= 1'b0;
      rq.wvalid <= 1'b0;
      @(posedge aclk);
      rq.bready <= 1'b1;
      do
      begin
        @(posedge aclk);
        i++;
      end
      while (!rs.bvalid && i < LIM);
      rq.bready <= 1'b0;
      bnd(i);
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int i;
    begin
      rq.arvalid <= 1'b1;
      rq.araddr <= a;
      i = 0;
      do
      begin
        @(posedge aclk);
        i++;
      end
      while (!rs.arready && i < LIM);
      rq.arvalid <= 1'b0;
      @(posedge aclk);
      rq.rready <= 1'b1;
      do
      begin
        @(posedge aclk);
        i++;
      end
      while (!rs.rvalid && i < LIM);
      d = rs.rdata;
      rr = rs.rresp;
      rq.rready <= 1'b0;
      bnd(i);
    end
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(d, e)
  endtask : rchk
  task automatic key(input logic [4:0] k);
    wr(OFS_KEY, 32'(k));
  endtask : key
  // digits enter most significant first, unit key closes the entry
  task automatic enter(input logic [31:0] v);
    int q[$];
    begin
      do
      begin
        q.push_front(int'(v % 10));
        v = v / 10;
      end
      while (v != 0);
      foreach (q[j])
        key(5'(q[j]));
      key(KEY_HZ);
    end
  endtask : enter
  function automatic logic [31:0] inc(input int r);
    inc = (r == 0) ? TUNE_FINE_HZ : (r == 1) ? TUNE_MED_HZ : (r == 2) ? TUNE_COARSE_HZ : t;
  endfunction : inc
  function automatic logic [31:0] rnd(input int lo, input int span);
    rnd = 32'(lo + ({$random(seed)} % span));
  endfunction : rnd
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    c = rnd(20000, 900000);
    s = rnd(1, 9999);
    t = rnd(1, 9999);
    w = rnd(10000, 90000);
    rchk(OFS_STEP, 32'h0);
    enter(c);
    key(KEY_CF);
    rchk(OFS_KEYBOARD, c);
    rchk(OFS_CENTER, c);
    rchk(OFS_READOUT, c);
    enter(s);
    key(KEY_UP);
    rchk(OFS_STEP, s);
    key(KEY_UP);
    rchk(OFS_CENTER, c + 2 * s);
    enter(t);
    key(KEY_DOWN);
    rchk(OFS_STEP, t);
    c = c + 2 * s - t;
    rchk(OFS_CENTER, c);
    key(KEY_CLEAR);
    rchk(OFS_KEYBOARD, 32'h0);
    rchk(OFS_STEP, t);
    enter(32'h77359401);
    key(KEY_CF);
    rchk(OFS_KEYBOARD, 32'h77359400);
    rchk(OFS_CENTER, c);
    enter(w);
    key(KEY_WIDTH);
    rchk(OFS_WIDTH, w);
    wr(OFS_CTRL, 32'h40);
    rchk(OFS_READOUT, w);
    wr(OFS_CTRL, 32'h80);
    rchk(OFS_READOUT, t);
    wr(OFS_CTRL, 32'h100);
    rchk(OFS_READOUT, w);
    for (n = 0; n < 4; n++)
    begin
      wr(OFS_CTRL, 32'(n) << 4);
      panel.turn(1'b1);
      c = c + inc(n);
      rchk(OFS_OUTPUT, c);
    end
    panel.turn(1'b0);
    c = c - t;
    rchk(OFS_OUTPUT, c);
    enter(5000);
    key(KEY_CF);
    repeat (4) @(posedge aclk);
    `CHK(lamp, 1'b1)
    rchk(OFS_CENTER, 32'd5000);
    enter(c);
    key(KEY_CF);
    wr(OFS_CTRL, 32'(MODE_SINGLE));
    key(KEY_SINGLE);
    for (n = 0; !swl && n < 20; n++) @(posedge aclk);
    `CHK(ro, c)
    for (n = 0; swl && n < LIM; n++) @(posedge aclk);
    bnd(n);
    `CHK(n >= 100 * CPM && n <= 102 * CPM, 1'b1)
    repeat (3) @(posedge aclk);
    `CHK(fw, c)
    wr(OFS_CTRL, 32'(MODE_MAN));
    panel.turn(1'b1);
    rchk(OFS_OUTPUT, c - w / 2 + w / 1000 * 501);
    `CHK(ro, d)
    wr(OFS_CTRL, 32'(MODE_AUTO));
    repeat (1015) @(posedge aclk);
    `CHK(swl, 1'b1)
    rsn <= 1'b0;
    repeat (4) @(posedge aclk);
    key(KEY_UP);
    rchk(OFS_CENTER, c);
    wr(OFS_RKEY, 32'(KEY_UP));
    rchk(OFS_CENTER, c + t);
    sb <= 1'b1;
    repeat (4) @(posedge aclk);
    rchk(OFS_STEP, 32'h0);
    rd(8'hFC);
    `CHK(rr, RESP_SLVERR)
    finish_test();
  end
endmodule : frequency_entry_sweep_control_tb
`default_nettype wire
